/* src/nfh_pkg.sv */
// package for the nand flash host controller: geometry, command codes,
// timing, operation table and the structs that carry requests and pins.
// assumes a 200 MHz clock and a device answering on 8 or 16 i/o lines.
package nfh_pkg;

    // clock and pin timing; times in ns, counts derived, least times round up
    localparam int CLK_PERIOD_NS     = 5;
    localparam int STROBE_LOW_NS     = 30;
    localparam int STROBE_HIGH_NS    = 20;
    localparam int BUSY_SETTLE_NS    = 100;
    localparam int STROBE_LOW_CYC    =
        (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_HIGH_CYC   =
        (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUSY_SETTLE_CYC   =
        (BUSY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W             = 8;

    // array geometry
    localparam int PAGE_BYTES        = 2112;
    localparam int PAGE_WORDS        = 1056;
    localparam int SPARE_COL_X8      = 2048;
    localparam int SPARE_COL_X16     = 1024;
    localparam int PAGE_COUNT        = 65536;
    localparam int BLOCK_COUNT       = 1024;
    localparam int PAGES_PER_BLOCK   = 64;
    localparam int ADDR_BITS_X8      = 28;
    localparam int ADDR_BITS_X16     = 27;
    localparam int COL_W             = 12;
    localparam int ROW_W             = 16;
    localparam int LEN_W             = 12;
    localparam int IO_W              = 16;
    localparam int FIFO_DEPTH        = 4;

    // address cycle layout: two column bytes, then two row bytes
    localparam logic [2:0] ADDR_COL_LO = 3'h0;
    localparam logic [2:0] ADDR_COL_HI = 3'h1;
    localparam logic [2:0] ADDR_ROW_LO = 3'h2;
    localparam logic [2:0] ADDR_ROW_HI = 3'h3;
    localparam logic [2:0] ADDR_END    = 3'h4;
    localparam logic [7:0] COL_HI_MASK_X8  = 8'h0f;
    localparam logic [7:0] COL_HI_MASK_X16 = 8'h07;

    // command codes
    localparam logic [7:0] CMD_READ_SETUP   = 8'h00;
    localparam logic [7:0] CMD_READ_GO      = 8'h30;
    localparam logic [7:0] CMD_READ_COPY_GO = 8'h35;
    localparam logic [7:0] CMD_READ_ID      = 8'h90;
    localparam logic [7:0] CMD_RESET        = 8'hff;
    localparam logic [7:0] CMD_PROG_SETUP   = 8'h80;
    localparam logic [7:0] CMD_PROG_GO      = 8'h10;
    localparam logic [7:0] CMD_CACHE_GO     = 8'h15;
    localparam logic [7:0] CMD_COPY_SETUP   = 8'h85;
    localparam logic [7:0] CMD_ERASE_SETUP  = 8'h60;
    localparam logic [7:0] CMD_ERASE_GO     = 8'hd0;
    localparam logic [7:0] CMD_RAND_OUT     = 8'h05;
    localparam logic [7:0] CMD_RAND_OUT_GO  = 8'he0;
    localparam logic [7:0] CMD_STATUS       = 8'h70;
    localparam logic [7:0] CMD_NONE         = 8'h00;

    // operations the host offers its user
    typedef enum logic [3:0] {
        OP_READ      = 4'h0,
        OP_READ_COPY = 4'h1,
        OP_READ_ID   = 4'h2,
        OP_RESET     = 4'h3,
        OP_PROGRAM   = 4'h4,
        OP_CACHE_PRG = 4'h5,
        OP_COPY_PRG  = 4'h6,
        OP_ERASE     = 4'h7,
        OP_RAND_IN   = 4'h8,
        OP_RAND_OUT  = 4'h9,
        OP_STATUS    = 4'ha,
        OP_AUTO_READ = 4'hb
    } nfhOp_t;

    typedef struct packed {
        nfhOp_t             op;
        logic [COL_W-1:0]   column;
        logic [ROW_W-1:0]   row;
        logic [LEN_W-1:0]   len;
    } nfhReq_t;

    typedef struct packed {
        logic ceN;
        logic cle;
        logic ale;
        logic weN;
        logic readStrobeN;
        logic wpN;
    } nfhPins_t;

    // how one operation walks the bus
    typedef struct packed {
        logic       hasCmd1;
        logic [7:0] cmd1;
        logic [2:0] addrFirst;
        logic [2:0] addrLast;
        logic       hasData;
        logic       dataRead;
        logic       hasCmd2;
        logic [7:0] cmd2;
        logic       waitBusy;
    } nfhOpInfo_t;

    function automatic nfhOpInfo_t nfhDecode(input nfhOp_t op);
        nfhOpInfo_t i;
        i = '{1'b1, CMD_NONE, ADDR_COL_LO, ADDR_END, 1'b0, 1'b0,
              1'b0, CMD_NONE, 1'b1};
        unique case (op)
            OP_READ: begin
                i.cmd1 = CMD_READ_SETUP;
                i.hasCmd2 = 1'b1;
                i.cmd2 = CMD_READ_GO;
                i.hasData = 1'b1;
                i.dataRead = 1'b1;
            end
            OP_READ_COPY: begin
                i.cmd1 = CMD_READ_SETUP;
                i.hasCmd2 = 1'b1;
                i.cmd2 = CMD_READ_COPY_GO;
            end
            OP_READ_ID, OP_STATUS, OP_RESET: begin
                i.cmd1 = (op == OP_READ_ID) ? CMD_READ_ID :
                         (op == OP_STATUS) ? CMD_STATUS : CMD_RESET;
                i.addrFirst = ADDR_END;
                i.hasData = (op != OP_RESET);
                i.dataRead = 1'b1;
            end
            OP_PROGRAM, OP_CACHE_PRG: begin
                i.cmd1 = CMD_PROG_SETUP;
                i.hasData = 1'b1;
                i.hasCmd2 = 1'b1;
                i.cmd2 = (op == OP_PROGRAM) ? CMD_PROG_GO : CMD_CACHE_GO;
            end
            OP_COPY_PRG: begin
                i.cmd1 = CMD_COPY_SETUP;
                i.hasCmd2 = 1'b1;
                i.cmd2 = CMD_PROG_GO;
            end
            OP_ERASE: begin
                i.cmd1 = CMD_ERASE_SETUP;
                i.addrFirst = ADDR_ROW_LO;
                i.hasCmd2 = 1'b1;
                i.cmd2 = CMD_ERASE_GO;
            end
            OP_RAND_IN: begin
                i.cmd1 = CMD_COPY_SETUP;
                i.addrLast = ADDR_ROW_LO;
                i.hasData = 1'b1;
                i.waitBusy = 1'b0;
            end
            OP_RAND_OUT: begin
                i.cmd1 = CMD_RAND_OUT;
                i.addrLast = ADDR_ROW_LO;
                i.hasCmd2 = 1'b1;
                i.cmd2 = CMD_RAND_OUT_GO;
                i.hasData = 1'b1;
                i.dataRead = 1'b1;
            end
            OP_AUTO_READ: begin
                i.hasCmd1 = 1'b0;
                i.addrFirst = ADDR_END;
                i.hasData = 1'b1;
                i.dataRead = 1'b1;
            end
            default: i.hasCmd1 = 1'b0;
        endcase
        return i;
    endfunction

endpackage

/* src/nfh_fifo.sv */
// small first-in first-out buffer with valid/ready on both sides.
// assumes one clock and a synchronised active-low reset from its parent.
`timescale 1ns/1ps
module nfh_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rstN,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
    logic [PW:0]      count_reg, count_next;
    logic             notFull_reg, notFull_next, notEmpty_reg, notEmpty_next;
    logic             push, pop;

    // flags are registered so the user-facing ready comes from a flop
    always_comb begin
        push = inValid && notFull_reg;
        pop = outReady && notEmpty_reg;
        wrPtr_next = push ? PW'((32'(wrPtr_reg) + 1) % DEPTH) : wrPtr_reg;
        rdPtr_next = pop ? PW'((32'(rdPtr_reg) + 1) % DEPTH) : rdPtr_reg;
        count_next = count_reg + (PW+1)'(push) - (PW+1)'(pop);
        notFull_next = (32'(count_next) < DEPTH);
        notEmpty_next = (count_next != '0);
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
            notFull_reg <= 1'b1;
            notEmpty_reg <= 1'b0;
        end else begin
            wrPtr_reg <= wrPtr_next;
            rdPtr_reg <= rdPtr_next;
            count_reg <= count_next;
            notFull_reg <= notFull_next;
            notEmpty_reg <= notEmpty_next;
        end
    end

    // storage has no reset; only written words are ever read
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_reg] <= inData;
        end
    end

    assign inReady = notFull_reg;
    assign outValid = notEmpty_reg;
    assign outData = mem[rdPtr_reg];
endmodule

/* src/nfh_host.sv */
// host-side controller that drives a page-organised nand flash over its
// command/address/data pins; program data passes through a small fifo.
// assumes all pin inputs are synchronous to clk and rbN is pulled up.
//
// Overview of operation
// - full address: two column then two row bytes
// - block erase sends only the two row bytes
// - command/address on low byte, upper lines low
// - cle marks command, ale marks address, else data
// - reset, status, id read are one command byte
// - read, program, erase use setup plus confirm code
// - read/program send four address bytes before confirm
// - copy-back: read with 00h/35h, program 85h/10h
// - random input 85h; random output 05h, column, E0h
// - host never sends undefined command codes
`timescale 1ns/1ps
module nfh_host
    import nfh_pkg::*;
#(
    parameter logic WIDE = 1'b0
) (
    input  wire logic            clk,
    input  wire logic            resetn,
    input  wire logic            reqValid,
    output logic                 reqReady,
    input  wire nfhReq_t         req,
    output logic                 doneValid,
    input  wire logic            wrValid,
    output logic                 wrReady,
    input  wire logic [IO_W-1:0] wrData,
    output logic                 rdValid,
    output logic [IO_W-1:0]      rdData,
    output nfhPins_t             pins,
    output logic [IO_W-1:0]      ioOut,
    output logic                 ioOe,
    input  wire logic [IO_W-1:0] ioIn,
    input  wire logic            rbN
);
    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_CMD1 = 6'h02,
        S_ADDR = 6'h04,
        S_DATA = 6'h08,
        S_CMD2 = 6'h10,
        S_BUSY = 6'h20
    } nfhState_t;

    logic rstMeta_reg, rstN;
    nfhState_t state_reg, state_next;
    nfhOpInfo_t info_reg, info_next;
    nfhReq_t req_reg, req_next;
    nfhPins_t pins_reg, pins_next;
    logic [IO_W-1:0] ioOut_reg, ioOut_next, rdData_reg, rdData_next;
    logic ioOe_reg, ioOe_next, rdValid_reg, rdValid_next;
    logic reqReady_reg, reqReady_next, doneValid_reg, doneValid_next;
    logic beatOn_reg, beatOn_next, beatLow_reg, beatLow_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [2:0] addrIdx_reg, addrIdx_next;
    logic [LEN_W-1:0] words_reg, words_next;
    logic fifoValid, fifoPop;
    logic [IO_W-1:0] fifoData;
    logic beatEnd, lowEnd;

    // reset release through two flops; only the second is used
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rstMeta_reg <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstMeta_reg <= 1'b1;
            rstN <= rstMeta_reg;
        end
    end

    // program data buffer; wrReady falls when full and stalls the user
    nfh_fifo #(.WIDTH(IO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk     (clk),
        .rstN    (rstN),
        .inValid (wrValid),
        .inReady (wrReady),
        .inData  (wrData),
        .outValid(fifoValid),
        .outReady(fifoPop),
        .outData (fifoData)
    );

    // one address byte; column high masked so unused lines stay low
    function automatic logic [7:0] addrByte(input logic [2:0] idx,
                                            input nfhReq_t r);
        logic [7:0] b;
        b = 8'h00;
        unique case (idx)
            ADDR_COL_LO: b = r.column[7:0];
            ADDR_COL_HI: b = 8'(r.column[COL_W-1:8]) &
                             (WIDE ? COL_HI_MASK_X16 : COL_HI_MASK_X8);
            ADDR_ROW_LO: b = r.row[7:0];
            ADDR_ROW_HI: b = r.row[ROW_W-1:8];
            default:     b = 8'h00;
        endcase
        return b;
    endfunction

    assign lowEnd = beatOn_reg && beatLow_reg && (cnt_reg == '0);
    assign beatEnd = beatOn_reg && !beatLow_reg && (cnt_reg == '0);
    // no pop once the length is used up, so spare words stay queued
    assign fifoPop = (state_reg == S_DATA) && !info_reg.dataRead &&
                     !beatOn_reg && fifoValid && (words_reg != '0);

    // sequencer: each bus beat is strobe low then strobe high
    always_comb begin
        state_next = state_reg;
        info_next = info_reg;
        req_next = req_reg;
        pins_next = pins_reg;
        ioOut_next = ioOut_reg;
        ioOe_next = ioOe_reg;
        rdData_next = rdData_reg;
        rdValid_next = 1'b0;
        reqReady_next = reqReady_reg;
        doneValid_next = 1'b0;
        beatOn_next = beatOn_reg;
        beatLow_next = beatLow_reg;
        cnt_next = (cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;
        addrIdx_next = addrIdx_reg;
        words_next = words_reg;
        // end of low half: raise the strobe, the device latches here
        if (lowEnd) begin
            beatLow_next = 1'b0;
            cnt_next = CNT_W'(STROBE_HIGH_CYC - 1);
            pins_next.weN = 1'b1;
            pins_next.readStrobeN = 1'b1;
            if (state_reg == S_DATA && info_reg.dataRead) begin
                rdData_next = WIDE ? ioIn : {8'h00, ioIn[7:0]};
                rdValid_next = 1'b1;
            end
        end
        unique case (state_reg)
            S_IDLE: begin
                pins_next.ceN = 1'b1;
                pins_next.cle = 1'b0;
                pins_next.ale = 1'b0;
                pins_next.wpN = 1'b0; // protects the array between ops
                ioOe_next = 1'b0;
                if (reqValid && reqReady_reg) begin
                    req_next = req;
                    info_next = nfhDecode(req.op); // only legal codes
                    addrIdx_next = info_next.addrFirst;
                    words_next = req.len;
                    reqReady_next = 1'b0;
                    pins_next.ceN = 1'b0;
                    pins_next.wpN = 1'b1;
                    // auto-read skips the command and goes through the busy wait to the data phase
                    state_next = info_next.hasCmd1 ? S_CMD1 : S_BUSY;
                    cnt_next = CNT_W'(BUSY_SETTLE_CYC);
                end
            end
            S_CMD1, S_CMD2: begin
                if (!beatOn_reg) begin
                    // command byte on the low lines with cle high
                    beatOn_next = 1'b1;
                    beatLow_next = 1'b1;
                    cnt_next = CNT_W'(STROBE_LOW_CYC - 1);
                    pins_next.cle = 1'b1;
                    pins_next.ale = 1'b0;
                    pins_next.weN = 1'b0;
                    ioOe_next = 1'b1;
                    ioOut_next = {8'h00, (state_reg == S_CMD1) ?
                                  info_reg.cmd1 : info_reg.cmd2};
                end else if (beatEnd) begin
                    beatOn_next = 1'b0;
                    pins_next.cle = 1'b0;
                    cnt_next = CNT_W'(BUSY_SETTLE_CYC);
                    // one-byte commands skip the confirm
                    if (state_reg == S_CMD1 &&
                        info_reg.addrFirst != info_reg.addrLast) begin
                        state_next = S_ADDR;
                    end else if (state_reg == S_CMD1 && info_reg.hasData &&
                                 !info_reg.dataRead) begin
                        state_next = S_DATA;
                    end else if (state_reg == S_CMD1 && info_reg.hasCmd2) begin
                        state_next = S_CMD2; // setup then confirm
                    end else begin
                        state_next = S_BUSY;
                    end
                end
            end
            S_ADDR: begin
                if (!beatOn_reg) begin
                    // address bytes in column-then-row order
                    beatOn_next = 1'b1;
                    beatLow_next = 1'b1;
                    cnt_next = CNT_W'(STROBE_LOW_CYC - 1);
                    pins_next.ale = 1'b1;
                    pins_next.weN = 1'b0;
                    ioOe_next = 1'b1;
                    ioOut_next = {8'h00, addrByte(addrIdx_reg, req_reg)};
                end else if (beatEnd) begin
                    beatOn_next = 1'b0;
                    addrIdx_next = addrIdx_reg + 3'h1;
                    // erase stops after row bytes, random ops after column
                    if (addrIdx_reg + 3'h1 == info_reg.addrLast) begin
                        pins_next.ale = 1'b0;
                        cnt_next = CNT_W'(BUSY_SETTLE_CYC);
                        // all address bytes precede data or confirm
                        if (info_reg.hasData && !info_reg.dataRead) begin
                            state_next = S_DATA;
                        end else if (info_reg.hasCmd2) begin
                            state_next = S_CMD2;
                        end else begin
                            state_next = S_BUSY;
                        end
                    end
                end
            end
            S_DATA: begin
                if (!beatOn_reg && words_reg == '0) begin
                    ioOe_next = 1'b0;
                    cnt_next = CNT_W'(BUSY_SETTLE_CYC);
                    // program confirms after data, cache included
                    state_next = (info_reg.hasCmd2 && !info_reg.dataRead) ?
                                 S_CMD2 : S_BUSY;
                    if (info_reg.dataRead) begin
                        info_next.waitBusy = 1'b0;
                        info_next.hasData = 1'b0;
                    end
                end else if (!beatOn_reg && info_reg.dataRead) begin
                    // each read strobe fall gives the next word
                    beatOn_next = 1'b1;
                    beatLow_next = 1'b1;
                    cnt_next = CNT_W'(STROBE_LOW_CYC - 1);
                    pins_next.readStrobeN = 1'b0;
                    ioOe_next = 1'b0;
                end else if (!beatOn_reg && fifoValid) begin
                    // data beat: cle and ale both low
                    beatOn_next = 1'b1;
                    beatLow_next = 1'b1;
                    cnt_next = CNT_W'(STROBE_LOW_CYC - 1);
                    pins_next.weN = 1'b0;
                    ioOe_next = 1'b1;
                    ioOut_next = WIDE ? fifoData : {8'h00, fifoData[7:0]};
                end else if (beatEnd) begin
                    beatOn_next = 1'b0;
                    words_next = words_reg - 1'b1;
                end
            end
            S_BUSY: begin
                ioOe_next = 1'b0;
                // settle, then hold off until ready/busy is high
                if (cnt_reg == '0 && rbN) begin
                    if (info_reg.hasData && info_reg.dataRead) begin
                        state_next = S_DATA;
                    end else begin
                        state_next = S_IDLE;
                        reqReady_next = 1'b1;
                        doneValid_next = 1'b1;
                        pins_next.ceN = 1'b1;
                    end
                end
            end
            default: state_next = S_IDLE;
        endcase
    end

    // registers of the sequencer and the pin drivers
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            state_reg <= S_IDLE;
            info_reg <= '0;
            req_reg <= '0;
            pins_reg <= '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
            ioOut_reg <= '0;
            ioOe_reg <= 1'b0;
            rdData_reg <= '0;
            rdValid_reg <= 1'b0;
            reqReady_reg <= 1'b1;
            doneValid_reg <= 1'b0;
            beatOn_reg <= 1'b0;
            beatLow_reg <= 1'b0;
            cnt_reg <= '0;
            addrIdx_reg <= '0;
            words_reg <= '0;
        end else begin
            state_reg <= state_next;
            info_reg <= info_next;
            req_reg <= req_next;
            pins_reg <= pins_next;
            ioOut_reg <= ioOut_next;
            ioOe_reg <= ioOe_next;
            rdData_reg <= rdData_next;
            rdValid_reg <= rdValid_next;
            reqReady_reg <= reqReady_next;
            doneValid_reg <= doneValid_next;
            beatOn_reg <= beatOn_next;
            beatLow_reg <= beatLow_next;
            cnt_reg <= cnt_next;
            addrIdx_reg <= addrIdx_next;
            words_reg <= words_next;
        end
    end

    assign reqReady = reqReady_reg;
    assign doneValid = doneValid_reg;
    assign rdValid = rdValid_reg;
    assign rdData = rdData_reg;
    assign pins = pins_reg;
    assign ioOut = ioOut_reg;
    assign ioOe = ioOe_reg;
endmodule

/* testbench/nfh_host_chk.sv */
// checker: pin framing, strobe width and request handshake.
// sees only host ports; bound into nfh_host at the foot.
`timescale 1ns/1ps
module nfh_host_chk import nfh_pkg::*; (
    input wire logic            clk,
    input wire logic            resetn,
    input wire logic            reqValid,
    input wire logic            reqReady,
    input wire logic            doneValid,
    input wire nfhPins_t        pins,
    input wire logic [IO_W-1:0] ioOut,
    input wire logic            rbN
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence wePulse;
        (!pins.weN) [*6] ##1 pins.weN;
    endsequence
    a_strobe_width: assert property ($fell(pins.weN) |-> wePulse)
        else $error("write strobe width");
    a_cmd_low: assert property (pins.cle && !pins.weN
        |-> ioOut[15:8] == 8'h00) else $error("command upper byte");
    a_addr_low: assert property (pins.ale && !pins.weN
        |-> ioOut[15:8] == 8'h00) else $error("address upper byte");
    a_latch_excl: assert property (!(pins.cle && pins.ale))
        else $error("both latch enables");
    a_strobe_sel: assert property (!pins.weN |-> !pins.ceN)
        else $error("strobe while deselected");
    a_take_sel: assert property (reqValid && reqReady
        |=> !reqReady && !pins.ceN) else $error("take");
    a_ready_back: assert property (doneValid |=> reqReady)
        else $error("ready after done");
    a_done_rb: assert property (doneValid |-> $past(rbN))
        else $error("done while busy");
endmodule
bind nfh_host nfh_host_chk nfh_host_chk_i (.clk(clk), .resetn(resetn),
    .reqValid(reqValid), .reqReady(reqReady), .doneValid(doneValid),
    .pins(pins), .ioOut(ioOut), .rbN(rbN));

/* testbench/nfh_flash_model.sv */
// flash stand-in: latches on strobe rise, keeps a 64-word page slice.
// assumes one host; busy lasts BUSY_NS after a confirm code.
`timescale 1ns/1ps
module nfh_flash_model
    import nfh_pkg::*;
#(parameter int BUSY_NS = 200) (
    input  wire nfhPins_t        pins,
    input  wire logic [IO_W-1:0] ioOut,
    input  wire logic            ioOe,
    output logic [IO_W-1:0]      ioIn,
    output logic                 rbN
);
    logic [15:0] mem [0:63]; // slice of one whole page
    logic [7:0]  ab [0:3];   // address bytes; only the column pair picks the word
    logic [15:0] drv = 16'h5a5a;
    logic [11:0] col = 12'h0;
    logic [7:0]  lastCmd = 8'h0, c;
    logic [2:0]  nAddr = 3'h0, k;
    logic        err = 1'b0, busyN = 1'b1;
    // host drive wins while enabled; open-drain busy is pulled up
    assign ioIn = ioOe ? ioOut : drv;
    assign rbN = busyN;
    // select tied high: first page readable at power-up
    initial mem[0] = 16'h0a5e;
    // bytes count only on a selected write strobe rise
    always @(posedge pins.weN) if (!pins.ceN) begin
        c = ioOut[7:0];
        err |= (pins.cle || pins.ale) && ioOut[15:8] != 8'h0;
        if (pins.cle) begin
            err |= !(c inside {8'h00, 8'h30, 8'h35, 8'h90, 8'hff, 8'h80,
                8'h10, 8'h15, 8'h85, 8'h60, 8'hd0, 8'h05, 8'he0,
                8'h70});
            err |= !busyN && c != 8'hff && c != 8'h70;
            lastCmd = c;
            nAddr = (c == 8'hd0) ? nAddr : 3'h0; // erase count kept
            if (c inside {8'h30, 8'h35, 8'h10, 8'h15, 8'hd0}) begin
                busyN = 1'b0;
                busyN <= #(BUSY_NS) 1'b1;
            end
        end else if (pins.ale) begin
            k = nAddr + ((lastCmd == 8'h60) ? 3'h2 : 3'h0);
            if (k < 3'h4) ab[k[1:0]] = c;
            if (nAddr < 3'h4) nAddr += 3'h1;
            col = {ab[1][3:0], ab[0]};
        end else begin
            mem[col[5:0]] = ioOut;
            col += 12'h1;
        end
    end
    // each read strobe fall shows the next word
    always @(negedge pins.readStrobeN) begin
        drv = (lastCmd == 8'h70) ? {9'h0, busyN, 6'h0} : mem[col[5:0]];
        col += 12'h1;
    end
    // a released bus must not look like held data
    always @(posedge pins.readStrobeN) drv = ~drv;
endmodule

/* testbench/test_nand_command_address_interface.sv */
// bench: program, read back, random out, status, command table.
// drives nfh_host against nfh_flash_model; checker is bound in.
`timescale 1ns/1ps
module test_nand_command_address_interface import nfh_pkg::*; ;
    logic clk = 1'b0, resetn = 1'b0, reqValid = 1'b0, wrValid = 1'b0;
    logic reqReady, doneValid, wrReady, rdValid, ioOe, rbN;
    logic [IO_W-1:0] wrData = '0, rdData, ioOut, ioIn;
    nfhReq_t req = '0;
    nfhPins_t pins;
    logic [15:0] rq [$];
    int nErrors = 0, comparisons = 0, cyc = 0;
    nfh_host #(.WIDE(1'b1)) nfh_host_i (.clk(clk), .resetn(resetn),
        .reqValid(reqValid), .reqReady(reqReady), .req(req),
        .doneValid(doneValid), .wrValid(wrValid), .wrReady(wrReady),
        .wrData(wrData), .rdValid(rdValid), .rdData(rdData), .pins(pins),
        .ioOut(ioOut), .ioOe(ioOe), .ioIn(ioIn), .rbN(rbN));
    nfh_flash_model nfh_flash_model_i (.pins(pins), .ioOut(ioOut),
        .ioOe(ioOe), .ioIn(ioIn), .rbN(rbN));
    initial forever #2.5 clk = ~clk;
    // read words queue up; the scenario that asked judges them
    always @(posedge clk) if (rdValid) rq.push_back(rdData);
    // hang guard, far above the roughly 1300 cycles needed
    always @(posedge clk) if (++cyc == 20000) begin
        nErrors++;
        final_report();
    end
    task automatic check(input string what, input logic [15:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            nErrors++;
            $display("wrong value %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic run(input nfhOp_t op, input logic [11:0] c, n);
        rq.delete();
        req <= '{op, c, 16'h0123, n};
        reqValid <= 1'b1;
        do @(posedge clk); while (!reqReady);
        reqValid <= 1'b0;
        do @(posedge clk); while (!doneValid);
    endtask
    task automatic t_program;
        run(OP_AUTO_READ, 12'h000, 12'h001);
        check("auto read", rq[0], 16'h0a5e);
        for (int i = 0; i < 4; i++) begin
            wrData <= 16'h1100 + 16'(i);
            wrValid <= 1'b1;
            do @(posedge clk); while (!wrReady);
        end
        wrValid <= 1'b0;
        @(posedge clk);
        check("fifo full", 16'(wrReady), 16'h0);
        run(OP_PROGRAM, 12'h004, 12'h004);
        check("row hi", 16'(nfh_flash_model_i.ab[3]), 16'h1);
        check("drained", 16'(wrReady), 16'h1);
        $display("program test done");
    endtask
    task automatic t_read;
        run(OP_READ, 12'h004, 12'h004);
        for (int i = 0; i < 4; i++)
            check("read", rq[i], 16'h1100 + 16'(i));
        run(OP_RAND_OUT, 12'h006, 12'h002);
        check("rand out", rq[1], 16'h1103);
        run(OP_STATUS, 12'h000, 12'h001);
        check("status", rq[0], 16'h0040);
        $display("read test done");
    endtask
    task automatic t_codes;
        nfhOp_t ops [9] = '{OP_CACHE_PRG, OP_RAND_IN, OP_READ_COPY,
            OP_COPY_PRG, OP_RESET, OP_READ_ID, OP_RAND_OUT, OP_STATUS,
            OP_ERASE};
        logic [7:0] cmd [9] = '{8'h15, 8'h85, 8'h35, 8'h10, 8'hff,
            8'h90, 8'he0, 8'h70, 8'hd0};
        for (int i = 0; i < 9; i++) begin
            run(ops[i], 12'h000, 12'h000);
            check("cmd", 16'(nfh_flash_model_i.lastCmd), 16'(cmd[i]));
        end
        check("erase", 16'(nfh_flash_model_i.nAddr), 16'h2);
        check("protocol", 16'(nfh_flash_model_i.err), 16'h0);
        $display("codes test done");
    endtask
    task automatic final_report;
        $display("compares %0d errors %0d", comparisons, nErrors);
        if (nErrors == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        t_program();
        t_read();
        t_codes();
        final_report();
    end
endmodule
